// >>> logic/cfp_fifo_pointers.sv
// per-fifo software-side and engine-side slot indices with wrap at the configured depth
`timescale 1ns/1ps
module cfp_fifo_pointers
  import cfp_pkg::*;
(
  // clock and reset
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  // control
  input  wire logic                               clear,
  input  wire logic [IDX_W-1:0]                   depth_m1,
  input  wire logic [NUM_FIFOS-1:0]               user_adv,
  input  wire logic [NUM_FIFOS-1:0]               eng_adv,
  // indices
  output logic [NUM_FIFOS-1:0][IDX_W-1:0]         user_idx,
  output logic [NUM_FIFOS-1:0][IDX_W-1:0]         eng_idx
);

  // configuration mode holds every pointer at slot zero, so reads there mean nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
      user_idx <= '0;
    else
      for (int n = 0; n < NUM_FIFOS; n++)
        if (user_adv[n])
          user_idx[n] <= cfp_wrap_inc(user_idx[n], depth_m1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
      eng_idx <= '0;
    else
      for (int n = 0; n < NUM_FIFOS; n++)
        if (eng_adv[n])
          eng_idx[n] <= cfp_wrap_inc(eng_idx[n], depth_m1);
  end

endmodule : cfp_fifo_pointers

// >>> logic/cfp_filter_route.sv
// acceptance filters eight to eleven: masked identifier compare and destination fifo choice
`timescale 1ns/1ps
module cfp_filter_route
  import cfp_pkg::*;
(
  // clock and reset
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  // configuration
  input  wire cfp_filter_type [NUM_FILTERS-1:0]  filters,
  input  wire logic [NUM_FILTERS-1:0][ID_W-1:0]  filter_ids,
  input  wire logic [3:0][ID_W-1:0]              masks,
  // incoming frame
  input  wire logic                              rx_valid,
  input  wire logic [ID_W-1:0]                   rx_id,
  // routing result
  output logic                                   route_valid,
  output logic [3:0]                             route_fifo
);

  logic       next_hit;
  logic [3:0] next_fifo;

  // highest index scanned first so the lowest numbered filter wins
  always_comb
  begin
    next_hit = 1'b0;
    next_fifo = 4'h0;
    for (int k = NUM_FILTERS - 1; k >= 0; k--)
    begin
      if (filters[k].filter_on
          && (((rx_id ^ filter_ids[k]) & masks[filters[k].accept_mask_select]) == '0)
          && (filters[k].dest_fifo_select < DEST_FIFO_SELECT_RESERVED_MIN))
      begin
        next_hit = 1'b1;
        next_fifo = filters[k].dest_fifo_select[3:0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      route_valid <= 1'b0;
      route_fifo <= 4'h0;
    end
    else
    begin
      route_valid <= rx_valid && next_hit;
      route_fifo <= next_fifo;
    end
  end

endmodule : cfp_filter_route

// >>> logic/cfp_pkg.sv
// shared constants, field layouts and carrier types for the filter routing and fifo pointer block
package cfp_pkg;

  localparam int ADDR_W = 8;
  localparam int NUM_FIFOS = 16;
  localparam int NUM_FILTERS = 4;
  localparam int ID_W = 11;
  localparam int IDX_W = 5;

  // register byte offsets
  localparam logic [7:0] ADDR_FILTER_WORD_TWO = 8'h00;
  localparam logic [7:0] ADDR_FIFO_TX = 8'h04;
  localparam logic [7:0] ADDR_FIFO_DEPTH = 8'h08;
  localparam logic [7:0] ADDR_CONFIG_MODE = 8'h0C;
  localparam logic [7:0] ADDR_USER_ADVANCE = 8'h10;
  localparam logic [7:0] ADDR_MASK_BASE = 8'h20;
  localparam logic [7:0] ADDR_FILTER_ID_BASE = 8'h30;
  localparam logic [7:0] ADDR_USER_ADDR_BASE = 8'h40;
  localparam logic [7:0] ADDR_MSG_INDEX_BASE = 8'h80;
  localparam logic [7:0] ADDR_REGION_MASK = 8'hC0;
  localparam logic [7:0] ADDR_SMALL_MASK = 8'hF0;

  // one filter slot per byte of filter control word two, filter eight in the low byte
  localparam int FILT_SLOT_W = 8;
  localparam int FILT_ON_BIT = 7;
  localparam int ACCEPT_MASK_SELECT_LSB = 5;
  localparam int DEST_FIFO_SELECT_LSB = 0;
  localparam logic [4:0] DEST_FIFO_SELECT_RESERVED_MIN = 5'h10;

  // reset values
  localparam logic [4:0] DEPTH_M1_RESET = 5'h1F;
  localparam logic CONFIG_MODE_RESET = 1'b1;

  // message slot geometry: 16 bytes per slot, 32 slots per fifo region
  localparam int MSG_SHIFT = 4;
  localparam logic [31:0] ADDR_ALIGN_MASK = 32'hFFFF_FFFC;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       filter_on;
    logic [1:0] accept_mask_select;
    logic [4:0] dest_fifo_select;
  } cfp_filter_type;

  typedef struct packed {
    logic       valid;
    logic [3:0] fifo;
    logic [31:0] addr;
  } cfp_store_type;

  function automatic logic [4:0] cfp_wrap_inc(input logic [4:0] idx, input logic [4:0] depth_m1);
    cfp_wrap_inc = (idx >= depth_m1) ? 5'h00 : 5'(idx + 5'h01);
  endfunction : cfp_wrap_inc

  function automatic logic [31:0] cfp_slot_addr(input logic [31:0] base, input logic [3:0] fifo,
                                                 input logic [4:0] idx);
    cfp_slot_addr = (base + (32'({fifo, idx}) << MSG_SHIFT)) & ADDR_ALIGN_MASK;
  endfunction : cfp_slot_addr

endpackage : cfp_pkg

// >>> logic/cfp_top.sv
// filter routing and fifo pointer block with its axi4-lite register slave
`timescale 1ns/1ps
module cfp_top
  import cfp_pkg::*;
#(
  parameter logic [31:0] MSG_RAM_BASE = 32'h0000_0000
)
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [ADDR_W-1:0]     awaddr,
  input  wire logic [2:0]            awprot,
  // axi4-lite write data
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  // axi4-lite write response
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  // axi4-lite read address
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [ADDR_W-1:0]     araddr,
  input  wire logic [2:0]            arprot,
  // axi4-lite read data
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  // protocol engine side
  input  wire logic                  rx_valid,
  input  wire logic [ID_W-1:0]       rx_id,
  input  wire logic                  tx_done_valid,
  input  wire logic [3:0]            tx_done_fifo,
  output cfp_store_type              rx_store,
  output logic [NUM_FIFOS-1:0]       fifo_is_transmit,
  output logic                       config_mode
);

  cfp_filter_type [NUM_FILTERS-1:0]  filters;
  logic [NUM_FILTERS-1:0][ID_W-1:0]  filter_ids;
  logic [3:0][ID_W-1:0]              masks;
  logic [IDX_W-1:0]                  depth_m1;
  logic [NUM_FIFOS-1:0]              user_adv;
  logic [NUM_FIFOS-1:0]              eng_adv;
  logic [NUM_FIFOS-1:0][IDX_W-1:0]   user_idx;
  logic [NUM_FIFOS-1:0][IDX_W-1:0]   eng_idx;
  logic                              route_valid;
  logic [3:0]                        route_fifo;

  logic                              aw_held;
  logic                              w_held;
  logic [ADDR_W-1:0]                 wr_addr;
  logic [31:0]                       wr_data;
  logic [3:0]                        wr_strb;
  logic                              wr_fire;
  logic [31:0]                       next_rdata;
  logic [1:0]                        next_rresp;
  logic [1:0]                        next_bresp;

  // write channel: address and data taken in either order, one write at a time
  assign wr_fire = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      aw_held <= 1'b0;
      wr_addr <= '0;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      wr_addr <= awaddr;
    end
    else if (bvalid && bready)
    begin
      awready <= 1'b1;
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready <= 1'b1;
      w_held <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      w_held <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end
    else if (bvalid && bready)
    begin
      wready <= 1'b1;
      w_held <= 1'b0;
    end
  end

  always_comb
  begin
    if (wr_addr == ADDR_FILTER_WORD_TWO || wr_addr == ADDR_FIFO_TX
        || wr_addr == ADDR_FIFO_DEPTH || wr_addr == ADDR_CONFIG_MODE
        || wr_addr == ADDR_USER_ADVANCE
        || (wr_addr & ADDR_SMALL_MASK) == ADDR_MASK_BASE
        || (wr_addr & ADDR_SMALL_MASK) == ADDR_FILTER_ID_BASE)
      next_bresp = RESP_OKAY;
    else if ((wr_addr & ADDR_REGION_MASK) == ADDR_USER_ADDR_BASE
             || (wr_addr & ADDR_REGION_MASK) == ADDR_MSG_INDEX_BASE)
      next_bresp = RESP_OKAY;  // read-only words ignore writes
    else
      next_bresp = RESP_SLVERR;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp <= next_bresp;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // filter control word two: enable always writable, other fields locked while enabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      filters <= '0;
    else if (wr_fire && wr_addr == ADDR_FILTER_WORD_TWO)
      for (int k = 0; k < NUM_FILTERS; k++)
        if (wr_strb[k])
        begin
          filters[k].filter_on <= wr_data[k*FILT_SLOT_W + FILT_ON_BIT];
          if (!filters[k].filter_on)
          begin
            filters[k].accept_mask_select <= wr_data[k*FILT_SLOT_W + ACCEPT_MASK_SELECT_LSB +: 2];
            filters[k].dest_fifo_select <= wr_data[k*FILT_SLOT_W + DEST_FIFO_SELECT_LSB +: 5];
          end
        end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      masks <= '0;
      filter_ids <= '0;
    end
    else if (wr_fire)
      for (int k = 0; k < 4; k++)
      begin
        if (wr_addr == 8'(ADDR_MASK_BASE + 8'(4 * k)))
          masks[k] <= wr_data[ID_W-1:0];
        if (wr_addr == 8'(ADDR_FILTER_ID_BASE + 8'(4 * k)))
          filter_ids[k] <= wr_data[ID_W-1:0];
      end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fifo_is_transmit <= '0;
      depth_m1 <= DEPTH_M1_RESET;
      config_mode <= CONFIG_MODE_RESET;
    end
    else if (wr_fire)
    begin
      if (wr_addr == ADDR_FIFO_TX)
        fifo_is_transmit <= wr_data[NUM_FIFOS-1:0];
      if (wr_addr == ADDR_FIFO_DEPTH)
        depth_m1 <= wr_data[IDX_W-1:0];
      if (wr_addr == ADDR_CONFIG_MODE)
        config_mode <= wr_data[0];
    end
  end

  // software tells the block it has filled (transmit) or emptied (receive) one slot
  assign user_adv = (wr_fire && wr_addr == ADDR_USER_ADVANCE) ? wr_data[NUM_FIFOS-1:0] : '0;

  // engine side: a routed frame fills a receive slot, a sent frame frees a transmit slot
  always_comb
  begin
    eng_adv = '0;
    if (route_valid && !fifo_is_transmit[route_fifo])
      eng_adv[route_fifo] = 1'b1;
    if (tx_done_valid && fifo_is_transmit[tx_done_fifo])
      eng_adv[tx_done_fifo] = 1'b1;
  end

  cfp_filter_route u_route (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .filters     (filters),
    .filter_ids  (filter_ids),
    .masks       (masks),
    .rx_valid    (rx_valid && !config_mode),
    .rx_id       (rx_id),
    .route_valid (route_valid),
    .route_fifo  (route_fifo)
  );

  cfp_fifo_pointers u_ptrs (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (config_mode),
    .depth_m1 (depth_m1),
    .user_adv (user_adv),
    .eng_adv  (eng_adv),
    .user_idx (user_idx),
    .eng_idx  (eng_idx)
  );

  // the store address is the slot the engine index points at before it advances
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_store <= '0;
    else
    begin
      rx_store.valid <= route_valid && !fifo_is_transmit[route_fifo];
      rx_store.fifo <= route_fifo;
      rx_store.addr <= cfp_slot_addr(MSG_RAM_BASE, route_fifo, eng_idx[route_fifo]);
    end
  end

  // read decode
  always_comb
  begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    if (araddr == ADDR_FILTER_WORD_TWO)
      next_rdata = 32'(filters);
    else if (araddr == ADDR_FIFO_TX)
      next_rdata = 32'(fifo_is_transmit);
    else if (araddr == ADDR_FIFO_DEPTH)
      next_rdata = 32'(depth_m1);
    else if (araddr == ADDR_CONFIG_MODE)
      next_rdata = 32'(config_mode);
    else if (araddr == ADDR_USER_ADVANCE)
      next_rdata = '0;
    else if ((araddr & ADDR_SMALL_MASK) == ADDR_MASK_BASE)
      next_rdata = 32'(masks[araddr[3:2]]);
    else if ((araddr & ADDR_SMALL_MASK) == ADDR_FILTER_ID_BASE)
      next_rdata = 32'(filter_ids[araddr[3:2]]);
    else if ((araddr & ADDR_REGION_MASK) == ADDR_USER_ADDR_BASE)
      // head for transmit, tail for receive: both are the software-side index
      next_rdata = cfp_slot_addr(MSG_RAM_BASE, araddr[5:2], user_idx[araddr[5:2]]);
    else if ((araddr & ADDR_REGION_MASK) == ADDR_MSG_INDEX_BASE)
      next_rdata = 32'(eng_idx[araddr[5:2]]);
    else
      next_rresp = RESP_SLVERR;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
    else if (rvalid && rready)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

endmodule : cfp_top

// >>> tb/cfp_engine_model.sv
// behavioural protocol engine: hands over frames, reports sent messages, takes slot stores
`timescale 1ns/1ps
module cfp_engine_model
  import cfp_pkg::*;
(
  // clock
  input  wire logic           aclk,
  // towards the block
  output logic                rx_valid,
  output logic [ID_W-1:0]     rx_id,
  output logic                tx_done_valid,
  output logic [3:0]          tx_done_fifo,
  // from the block
  input  wire cfp_store_type  rx_store
);
  int            n_store;
  cfp_store_type last_store;

  initial
  begin
    rx_valid      = 1'h0;
    rx_id         = 11'h000;
    tx_done_valid = 1'h0;
    tx_done_fifo  = 4'h0;
    n_store       = 0;
    last_store    = '0;
  end

  // each routed frame fills the slot the block names
  always @(posedge aclk)
  begin
    if (rx_store.valid === 1'h1)
    begin
      n_store    <= n_store + 1;
      last_store <= rx_store;
    end
  end

  task automatic send_frame(input logic [ID_W-1:0] id);
    @(posedge aclk);
    rx_valid <= 1'h1;
    rx_id    <= id;
    @(posedge aclk);
    rx_valid <= 1'h0;
    // idle id lines carry nothing; show them moving so stale values are not trusted
    rx_id    <= ~id;
  endtask : send_frame

  task automatic sent_one(input logic [3:0] fifo);
    @(posedge aclk);
    tx_done_valid <= 1'h1;
    tx_done_fifo  <= fifo;
    @(posedge aclk);
    tx_done_valid <= 1'h0;
    tx_done_fifo  <= ~fifo;
  endtask : sent_one
endmodule : cfp_engine_model

// >>> tb/cfp_top_assertions.sv
// property checker for the filter routing and fifo pointer block
`timescale 1ns/1ps
module cfp_top_assertions
  import cfp_pkg::*;
#(
  parameter logic [31:0] MSG_RAM_BASE = 32'h0000_0000
)
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // register reads
  input  wire logic                  arvalid,
  input  wire logic                  arready,
  input  wire logic [ADDR_W-1:0]     araddr,
  input  wire logic                  rvalid,
  input  wire logic [31:0]           rdata,
  input  wire logic [1:0]            rresp,
  // engine side
  input  wire logic                  rx_valid,
  input  wire cfp_store_type         rx_store,
  input  wire logic [NUM_FIFOS-1:0]  fifo_is_transmit,
  input  wire logic                  config_mode
);
  logic [ADDR_W-1:0] rd_addr;
  logic              rd_ok;

  // rdata belongs to the address taken one edge earlier
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_addr <= 8'h00;
    else if (arvalid && arready)
      rd_addr <= araddr;
  end
  assign rd_ok = rvalid && (rresp == RESP_OKAY);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_store_align: assert property (rx_store.valid |-> rx_store.addr[1:0] == 2'h0)
    else $error("store address not word aligned");
  chk_store_region: assert property (rx_store.valid |->
    4'((rx_store.addr - MSG_RAM_BASE) >> 9) == rx_store.fifo)
    else $error("store address outside its fifo region");
  chk_store_dir: assert property (rx_store.valid |-> !fifo_is_transmit[rx_store.fifo])
    else $error("frame stored into a transmit fifo");
  chk_store_cause: assert property (rx_store.valid |->
    $past(rx_valid, 2) && !$past(config_mode, 2))
    else $error("store without a frame outside configuration");
  chk_config_quiet: assert property (
    config_mode && $past(config_mode) && $past(config_mode, 2) |-> !rx_store.valid)
    else $error("store while in configuration mode");
  chk_user_align: assert property (rd_ok && rd_addr[7:6] == 2'h1 |-> rdata[1:0] == 2'h0)
    else $error("user address low bits not zero");
  chk_user_region: assert property (rd_ok && rd_addr[7:6] == 2'h1 |->
    4'((rdata - MSG_RAM_BASE) >> 9) == rd_addr[5:2])
    else $error("user address points into another fifo");
  chk_index_upper: assert property (rvalid && rd_addr[7:6] == 2'h2 |-> rdata[31:5] == 27'h0)
    else $error("message index upper bits not zero");

  cov_store: cover property (rx_store.valid);
  cov_user_read: cover property (rd_ok && rd_addr[7:6] == 2'h1);
  cov_slverr: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : cfp_top_assertions

bind cfp_top cfp_top_assertions #(.MSG_RAM_BASE(MSG_RAM_BASE)) u_chk (
  .aclk             (aclk),
  .aresetn          (aresetn),
  .arvalid          (arvalid),
  .arready          (arready),
  .araddr           (araddr),
  .rvalid           (rvalid),
  .rdata            (rdata),
  .rresp            (rresp),
  .rx_valid         (rx_valid),
  .rx_store         (rx_store),
  .fifo_is_transmit (fifo_is_transmit),
  .config_mode      (config_mode)
);

// >>> tb/tb_top.sv
// register-level testbench for the filter routing and fifo pointer block
`timescale 1ns/1ps
module tb_top
  import cfp_pkg::*;
;
  logic                 aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready, rx_valid, tx_done_valid, config_mode;
  logic [ADDR_W-1:0]    awaddr, araddr;
  logic [31:0]          wdata, rdata;
  logic [3:0]           wstrb, tx_done_fifo;
  logic [1:0]           bresp, rresp;
  logic [ID_W-1:0]      rx_id;
  logic [NUM_FIFOS-1:0] fifo_is_transmit;
  cfp_store_type        rx_store;
  int                   err_total, total_checks;

  cfp_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .rx_valid(rx_valid), .rx_id(rx_id),
    .tx_done_valid(tx_done_valid), .tx_done_fifo(tx_done_fifo), .rx_store(rx_store),
    .fifo_is_transmit(fifo_is_transmit), .config_mode(config_mode));

  cfp_engine_model eng (.aclk(aclk), .rx_valid(rx_valid), .rx_id(rx_id),
    .tx_done_valid(tx_done_valid), .tx_done_fifo(tx_done_fifo), .rx_store(rx_store));

  always #50 aclk = ~aclk;

  task automatic close_out;
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // address and data offered together, each dropped at its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                        input logic [3:0] s = 4'hF);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1 && n < 50);
    bready <= 1'h0;
    check($sformatf("bresp at %h", a), 32'(er), 32'(bresp));
    // a response that never comes is a mismatch, not a quiet pass
    if (n >= 50)
    begin
      check("bvalid", 32'h1, 32'(bvalid));
      close_out;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'h1)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1 && n < 50);
    rready <= 1'h0;
    check($sformatf("rdata at %h", a), exp, rdata);
    check($sformatf("rresp at %h", a), 32'(er), 32'(rresp));
    if (n >= 50)
    begin
      check("rvalid", 32'h1, 32'(rvalid));
      close_out;
    end
  endtask : axi_rd

  // store lands two edges after the pulse; four leaves the model time to log it
  task automatic frame(input logic [10:0] id, input int exp_n, input logic [31:0] exp_a);
    eng.send_frame(id);
    repeat (4) @(posedge aclk);
    check("store count", 32'(exp_n), 32'(eng.n_store));
    check("store addr", exp_a, eng.last_store.addr);
  endtask : frame

  initial
  begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(ADDR_FILTER_WORD_TWO, 32'h0, RESP_OKAY);
    axi_rd(ADDR_FIFO_DEPTH, 32'h1F, RESP_OKAY);
    axi_rd(ADDR_CONFIG_MODE, 32'h1, RESP_OKAY);
    axi_rd(8'h14, 32'h0, RESP_SLVERR);
    axi_wr(ADDR_MASK_BASE, 32'h7FF, RESP_OKAY);
    axi_wr(ADDR_MASK_BASE + 8'h08, 32'h700, RESP_OKAY);
    axi_wr(ADDR_FILTER_ID_BASE, 32'h123, RESP_OKAY);
    axi_wr(ADDR_FILTER_ID_BASE + 8'h04, 32'h0F0, RESP_OKAY);
    axi_wr(ADDR_FILTER_ID_BASE + 8'h08, 32'h055, RESP_OKAY);
    axi_wr(ADDR_FILTER_WORD_TWO, 32'h0004_1043, RESP_OKAY);
    axi_rd(ADDR_FILTER_WORD_TWO, 32'h0004_1043, RESP_OKAY);
    axi_wr(ADDR_FILTER_WORD_TWO, 32'h0004_90C3, RESP_OKAY);
    axi_wr(ADDR_FILTER_WORD_TWO, 32'h0007_9FE5, RESP_OKAY);
    axi_rd(ADDR_FILTER_WORD_TWO, 32'h0007_90C3, RESP_OKAY);
    axi_wr(ADDR_FIFO_TX, 32'h20, RESP_OKAY);
    check("direction", 32'h20, 32'(fifo_is_transmit));
    axi_wr(ADDR_CONFIG_MODE, 32'h0, RESP_OKAY);
    check("config mode", 32'h0, 32'(config_mode));
    frame(11'h1FF, 1, 32'h600);
    frame(11'h0F0, 1, 32'h600);
    frame(11'h055, 1, 32'h600);
    frame(11'h123, 2, 32'h610);
    axi_rd(ADDR_MSG_INDEX_BASE + 8'h0C, 32'h2, RESP_OKAY);
    axi_rd(ADDR_USER_ADDR_BASE + 8'h0C, 32'h600, RESP_OKAY);
    axi_wr(ADDR_USER_ADVANCE, 32'h28, RESP_OKAY);
    axi_rd(ADDR_USER_ADDR_BASE + 8'h0C, 32'h610, RESP_OKAY);
    axi_rd(ADDR_USER_ADDR_BASE + 8'h14, 32'hA10, RESP_OKAY);
    eng.sent_one(4'h5);
    eng.sent_one(4'h3);
    axi_rd(ADDR_MSG_INDEX_BASE + 8'h14, 32'h1, RESP_OKAY);
    axi_rd(ADDR_MSG_INDEX_BASE + 8'h0C, 32'h2, RESP_OKAY);
    axi_wr(ADDR_FIFO_DEPTH, 32'h1, RESP_OKAY);
    axi_wr(ADDR_USER_ADVANCE, 32'h40, RESP_OKAY);
    axi_rd(ADDR_USER_ADDR_BASE + 8'h18, 32'hC10, RESP_OKAY);
    axi_wr(ADDR_USER_ADVANCE, 32'h40, RESP_OKAY);
    axi_rd(ADDR_USER_ADDR_BASE + 8'h18, 32'hC00, RESP_OKAY);
    axi_wr(8'h14, 32'h1, RESP_SLVERR);
    axi_wr(ADDR_USER_ADDR_BASE, 32'hFFFF_FFFF, RESP_OKAY);
    axi_rd(ADDR_USER_ADDR_BASE, 32'h0, RESP_OKAY);
    axi_wr(ADDR_FILTER_WORD_TWO, 32'hFFFF_FFFF, RESP_OKAY, 4'h4);
    axi_rd(ADDR_FILTER_WORD_TWO, 32'h00FF_90C3, RESP_OKAY);
    axi_wr(ADDR_CONFIG_MODE, 32'h1, RESP_OKAY);
    check("config mode", 32'h1, 32'(config_mode));
    frame(11'h123, 2, 32'h610);
    close_out;
  end
endmodule : tb_top
